// [dft_map.vh]
`ifndef DFT_MAP_VH
`define DFT_MAP_VH

// Clock rate in Hz
`define DFT_CLK_HZ 20000000
// Least hold time of the reset terminal, in ms
`define DFT_RST_HOLD_MS 100
// Recovery time after a reset is withdrawn, in ms
`define DFT_RECOVER_MS 1000
// Cycle counts of the times above at 20 MHz, sized to their counters
// Hold is one cycle past 0.1s, so exactly 0.1s is still too short
`define DFT_RST_HOLD_CYC 24'h1E8481
`define DFT_RECOVER_CYC 25'h1312D00
// Half period of the reset-in-progress flash, in cycles between toggles
`define DFT_FLASH_CYC 24'h4C4B40

// Display codes, 8 bits
`define DFT_DSP_NORMAL 8'h00
`define DFT_DSP_RESET 8'h01
`define DFT_DSP_BLANK 8'h02
`define DFT_DSP_ERR_BASE 8'h10
`define DFT_DSP_OC_STALL 8'h20
`define DFT_DSP_OV_STALL 8'h21
`define DFT_DSP_REGEN_PRE 8'h22
`define DFT_DSP_THERM_PRE 8'h23
`define DFT_DSP_PANEL_STOP 8'h24
`define DFT_DSP_MAINT 8'h25
`define DFT_DSP_UNDERVOLT 8'h26
`define DFT_DSP_FAN 8'h30
`define DFT_DSP_OC_ACCEL 8'h40
`define DFT_DSP_OC_CONST 8'h41
`define DFT_DSP_OC_DECEL 8'h42
`define DFT_DSP_OV_ACCEL 8'h43
`define DFT_DSP_OV_CONST 8'h44
`define DFT_DSP_OV_DECEL 8'h45
`define DFT_DSP_OTHER_BASE 8'h80
`define DFT_DSP_GENERIC 8'h0E

// Motion phase encoding
`define DFT_PH_ACCEL 2'h0
`define DFT_PH_CONST 2'h1
`define DFT_PH_DECEL 2'h2

// Warning bit positions in warning_flags
`define DFT_W_OC_STALL 0
`define DFT_W_OV_STALL 1
`define DFT_W_REGEN 2
`define DFT_W_THERM 3
`define DFT_W_PSTOP 4
`define DFT_W_MAINT 5
`define DFT_W_UV 6

`endif

// [dft_hold_timer.v]
`timescale 1ns/1ps
`default_nettype none
`include "dft_map.vh"

// Counts how long a level has stood; qualified once the hold is reached
module dft_hold_timer
#(
   parameter [23:0] HOLD_CYC = `DFT_RST_HOLD_CYC
)
(
   input wire clk,
   input wire sys_rst,
   input wire level,
   output reg qualified
);

   reg [23:0] count;

   // Restarts on every drop so a short pulse never qualifies
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         count <= 24'h000000;
         qualified <= 1'b0;
      end
      else if (!level)
      begin
         count <= 24'h000000;
         qualified <= 1'b0;
      end
      else if (count >= HOLD_CYC - 24'h000001)
         qualified <= 1'b1;
      else
         count <= count + 24'h000001;
   end

endmodule

`default_nettype wire

// [dft_trip_ctrl.v]
// Operation
// R01 - On a trip, display switches automatically to that fault's code.
// R02 - After a trip, output stays stopped and restart refused until reset.
// R03 - Every reset clears thermal integral and retry counter.
// R04 - Ready again about 1s after reset withdrawn; inoperative meanwhile.
// R05 - Stop key resets only while a trip is present.
// R06 - Power cycle resets the device and clears a latched trip.
// R07 - Reset terminal must stand longer than 0.1s to count.
// R08 - While reset terminal held, stay in reset and flash reset indication.
// R09 - Panel or parameter unit mistakes only show an error message.
// R10 - Warnings display without tripping.
// R11 - Alarms never trip; alarm output driven when enabled.
// R12 - Trip-class fault trips and asserts the fault output.
// R13 - Warning class: stalls, prealarms, panel stop, maintenance, undervoltage.
// R14 - Overcurrent and overvoltage trips coded by accel, constant, decel.
// R15 - Fault output is not retained after control power is lost.
// R16 - Flagged faults show generic code 14 on the older parameter unit.
// R17 - First fault code latched until reset; later faults ignored.
`timescale 1ns/1ps
`default_nettype none
`include "dft_map.vh"

module dft_trip_ctrl
#(
   parameter [23:0] RST_HOLD_CYC = `DFT_RST_HOLD_CYC,
   parameter [24:0] RECOVER_CYC = `DFT_RECOVER_CYC
)
(
   input wire clk,
   input wire sys_rst,
   input wire control_power_ok,
   input wire external_reset_terminal,
   input wire stop_key,
   input wire run_request,
   input wire [1:0] motion_phase,
   input wire overcurrent_fault,
   input wire overvoltage_fault,
   input wire [5:0] other_fault,
   input wire other_fault_flagged,
   input wire [6:0] warning_flags,
   input wire fan_failure_alarm,
   input wire alarm_output_enable,
   input wire [1:0] parameter_write_error_messages,
   input wire parameter_write_error,
   input wire legacy_parameter_unit,
   output reg output_enable,
   output reg fault_out,
   output reg alarm_out,
   output reg tripped,
   output reg recovering,
   output reg [7:0] panel_code,
   output reg [7:0] parameter_unit_code,
   output reg clear_thermal_and_retry
);

   localparam [1:0] ST_READY = 2'h0;
   localparam [1:0] ST_TRIP = 2'h1;
   localparam [1:0] ST_HOLD = 2'h2;
   localparam [1:0] ST_RECOVER = 2'h3;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [7:0] trip_code;
   reg trip_generic;
   reg [24:0] recover_count;
   reg [23:0] flash_count;
   reg flash_on;
   reg stop_key_d;
   reg [7:0] next_panel;
   wire term_ok;
   wire any_fault;
   wire stop_press;
   wire reset_req;

   // R14 phase coded trips
   // Code of an overcurrent or overvoltage trip per motion phase
   function [7:0] phase_code;
      input ov;
      input [1:0] ph;
      reg [7:0] base;
      begin
         base = ov ? `DFT_DSP_OV_ACCEL : `DFT_DSP_OC_ACCEL;
         case (ph)
            `DFT_PH_ACCEL: phase_code = base;
            `DFT_PH_CONST: phase_code = base + 8'h01;
            default: phase_code = base + 8'h02;
         endcase
      end
   endfunction

   // Lowest set warning bit picks the warning indication
   function [7:0] warn_code;
      input [6:0] w;
      begin
         if (w[`DFT_W_OC_STALL])
            warn_code = `DFT_DSP_OC_STALL;
         else if (w[`DFT_W_OV_STALL])
            warn_code = `DFT_DSP_OV_STALL;
         else if (w[`DFT_W_REGEN])
            warn_code = `DFT_DSP_REGEN_PRE;
         else if (w[`DFT_W_THERM])
            warn_code = `DFT_DSP_THERM_PRE;
         else if (w[`DFT_W_PSTOP])
            warn_code = `DFT_DSP_PANEL_STOP;
         else if (w[`DFT_W_MAINT])
            warn_code = `DFT_DSP_MAINT;
         else
            warn_code = `DFT_DSP_UNDERVOLT;
      end
   endfunction

   // R07 terminal hold qualify
   dft_hold_timer #(.HOLD_CYC(RST_HOLD_CYC)) dft_hold_timer_inst
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .level(external_reset_terminal),
      .qualified(term_ok)
   );

   assign any_fault = overcurrent_fault | overvoltage_fault |
                      (|other_fault);
   assign stop_press = stop_key & ~stop_key_d;
   // R05 stop key gating
   assign reset_req = term_ok | (stop_press & (state == ST_TRIP));

   // Next state of the trip sequencer
   always @*
   begin
      next_state = state;
      case (state)
         ST_READY:
            // R12 fault trips
            if (term_ok)
               next_state = ST_HOLD;
            else if (any_fault)
               next_state = ST_TRIP;
         ST_TRIP:
            // R02 refuse restart
            if (reset_req)
               next_state = term_ok ? ST_HOLD : ST_RECOVER;
         ST_HOLD:
            // R08 stay in reset
            if (!external_reset_terminal)
               next_state = ST_RECOVER;
         ST_RECOVER:
            if (term_ok)
               next_state = ST_HOLD;
            else if (recover_count == RECOVER_CYC - 25'h0000001)
               next_state = ST_READY;
         default:
            next_state = ST_READY;
      endcase
   end

   // Panel indication by priority: trip, reset, warning, alarm, error
   always @*
   begin
      next_panel = `DFT_DSP_NORMAL;
      if (next_state == ST_TRIP)
         // R01 auto fault display
         next_panel = (state == ST_TRIP) ? trip_code :
            (overcurrent_fault ? phase_code(1'b0, motion_phase) :
             overvoltage_fault ? phase_code(1'b1, motion_phase) :
             `DFT_DSP_OTHER_BASE | {2'b00, other_fault});
      else if (next_state == ST_HOLD)
         // R08 flashing indication
         next_panel = flash_on ? `DFT_DSP_RESET : `DFT_DSP_BLANK;
      else if (next_state == ST_RECOVER)
         next_panel = `DFT_DSP_BLANK;
      else if (|warning_flags)
         // R10 R13 warning display
         next_panel = warn_code(warning_flags);
      else if (fan_failure_alarm)
         next_panel = `DFT_DSP_FAN;
      else if (parameter_write_error)
         // R09 message only
         next_panel = `DFT_DSP_ERR_BASE |
                      {6'b000000, parameter_write_error_messages};
   end

   // Sequencer, latched trip code and recovery count
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= ST_RECOVER;
         trip_code <= `DFT_DSP_NORMAL;
         trip_generic <= 1'b0;
         recover_count <= 25'h0000000;
         stop_key_d <= 1'b0;
      end
      else if (!control_power_ok)
      begin
         // R06 power cycle
         state <= ST_RECOVER;
         trip_code <= `DFT_DSP_NORMAL;
         trip_generic <= 1'b0;
         recover_count <= 25'h0000000;
         stop_key_d <= 1'b0;
      end
      else
      begin
         state <= next_state;
         stop_key_d <= stop_key;
         // R17 latch first code
         if (state == ST_READY && next_state == ST_TRIP)
         begin
            trip_code <= next_panel;
            trip_generic <= ~overcurrent_fault & ~overvoltage_fault &
                            other_fault_flagged;
         end
         // R04 recovery count
         if (next_state == ST_RECOVER && state == ST_RECOVER)
            recover_count <= recover_count + 25'h0000001;
         else
            recover_count <= 25'h0000000;
      end
   end

   // Flash timebase for the reset indication
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flash_count <= 24'h000000;
         flash_on <= 1'b0;
      end
      else if (flash_count == `DFT_FLASH_CYC - 24'h000001)
      begin
         flash_count <= 24'h000000;
         flash_on <= ~flash_on;
      end
      else
         flash_count <= flash_count + 24'h000001;
   end

   // Registered outputs; loss of control power drops the enables and flags, blanks the codes, raises recovering and the clear
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         output_enable <= 1'b0;
         fault_out <= 1'b0;
         alarm_out <= 1'b0;
         tripped <= 1'b0;
         recovering <= 1'b1;
         panel_code <= `DFT_DSP_BLANK;
         parameter_unit_code <= `DFT_DSP_BLANK;
         clear_thermal_and_retry <= 1'b1;
      end
      else if (!control_power_ok)
      begin
         // R15 fault not retained
         output_enable <= 1'b0;
         fault_out <= 1'b0;
         alarm_out <= 1'b0;
         tripped <= 1'b0;
         recovering <= 1'b1;
         panel_code <= `DFT_DSP_BLANK;
         parameter_unit_code <= `DFT_DSP_BLANK;
         clear_thermal_and_retry <= 1'b1;
      end
      else
      begin
         // R02 output held stopped
         output_enable <= (next_state == ST_READY) & run_request;
         // R12 fault output
         fault_out <= (next_state == ST_TRIP);
         // R11 alarm output
         alarm_out <= fan_failure_alarm & alarm_output_enable;
         tripped <= (next_state == ST_TRIP);
         recovering <= (next_state == ST_HOLD) |
                       (next_state == ST_RECOVER);
         panel_code <= next_panel;
         // R16 generic code
         if (legacy_parameter_unit && next_state == ST_TRIP &&
             (state == ST_TRIP ? trip_generic :
              (~overcurrent_fault & ~overvoltage_fault &
               other_fault_flagged)))
            parameter_unit_code <= `DFT_DSP_GENERIC;
         else
            parameter_unit_code <= next_panel;
         // R03 clear integrals
         clear_thermal_and_retry <= (next_state == ST_HOLD) |
                                    (state != ST_RECOVER &&
                                     next_state == ST_RECOVER);
      end
   end

endmodule

`default_nettype wire

// [dft_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Stop key, reset terminal and supply seen by the drive
module dft_panel_model
(
   input wire logic clk,
   output logic stop_key,
   output logic external_reset_terminal,
   output logic control_power_ok
);
   // Supply present, key and terminal idle
   initial {stop_key, external_reset_terminal, control_power_ok} = 3'h1;
   task press();
      @(posedge clk) stop_key <= 1'b1;
      @(posedge clk) stop_key <= 1'b0;
   endtask
   task hold(input int n);
      @(posedge clk) external_reset_terminal <= 1'b1;
      repeat (n) @(posedge clk);
      external_reset_terminal <= 1'b0;
   endtask
   task power_cycle();
      @(posedge clk) control_power_ok <= 1'b0;
      repeat (3) @(posedge clk);
      control_power_ok <= 1'b1;
   endtask
endmodule
`default_nettype wire

// [dft_trip_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dft_map.vh"
module dft_trip_chk
#(
   parameter [23:0] HOLD_CYC = `DFT_RST_HOLD_CYC
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic control_power_ok,
   input wire logic external_reset_terminal,
   input wire logic stop_key,
   input wire logic [1:0] motion_phase,
   input wire logic overcurrent_fault,
   input wire logic output_enable,
   input wire logic fault_out,
   input wire logic tripped,
   input wire logic recovering,
   input wire logic [7:0] panel_code,
   input wire logic clear_thermal_and_retry
);
   // Samples the terminal has stood high so far; saturates, never wraps
   logic [23:0] term_run;
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         term_run <= 24'h000000;
      else if (!external_reset_terminal)
         term_run <= 24'h000000;
      else if (term_run != 24'hFFFFFF)
         term_run <= term_run + 24'h000001;
   end
   // One clock domain, so one default clock and reset
   default clocking dck @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_trip_blocks_out: assert property (tripped |-> !output_enable)
      else $error("output on while tripped");
   chk_oc_const_code: assert property (
      !tripped && !recovering && overcurrent_fault && motion_phase == 2'h1
      && control_power_ok && !external_reset_terminal
      |=> tripped && fault_out && panel_code == 8'h41)
      else $error("constant speed overcurrent trip wrong");
   chk_code_kept: assert property (
      $past(tripped) && tripped |-> $stable(panel_code))
      else $error("trip code changed while tripped");
   chk_stop_idle: assert property (
      !tripped && !recovering && $rose(stop_key) && control_power_ok
      && !external_reset_terminal |=> !recovering)
      else $error("stop key reset without a trip");
   chk_stop_reset: assert property (
      tripped && $rose(stop_key) && control_power_ok
      && !external_reset_terminal
      |=> !tripped && recovering && clear_thermal_and_retry)
      else $error("stop key did not reset the trip");
   chk_power_loss: assert property (
      !control_power_ok |=> !fault_out && !tripped && recovering)
      else $error("fault kept over power loss");
   chk_hold_flash: assert property (
      external_reset_terminal && term_run > HOLD_CYC |-> recovering
      && !output_enable && panel_code inside {8'h01, 8'h02})
      else $error("no reset indication while terminal held");
   chk_recover_len: assert property (
      $fell(external_reset_terminal) && recovering |=> recovering[*8])
      else $error("recovery ended too soon");
endmodule
bind dft_trip_ctrl dft_trip_chk #(.HOLD_CYC(RST_HOLD_CYC)) dft_trip_chk_inst
(
   .clk(clk),
   .sys_rst(sys_rst),
   .control_power_ok(control_power_ok),
   .external_reset_terminal(external_reset_terminal),
   .stop_key(stop_key),
   .motion_phase(motion_phase),
   .overcurrent_fault(overcurrent_fault),
   .output_enable(output_enable),
   .fault_out(fault_out),
   .tripped(tripped),
   .recovering(recovering),
   .panel_code(panel_code),
   .clear_thermal_and_retry(clear_thermal_and_retry)
);
`default_nettype wire

// [test_dft_trip_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dft_trip_ctrl;
   logic clk, sys_rst, run_request, overcurrent_fault, overvoltage_fault;
   logic other_fault_flagged, fan_failure_alarm, alarm_output_enable;
   logic parameter_write_error, legacy_parameter_unit;
   logic [1:0] motion_phase, parameter_write_error_messages;
   logic [5:0] other_fault;
   logic [6:0] warning_flags;
   wire stop_key, external_reset_terminal, control_power_ok, alarm_out;
   wire output_enable, fault_out, tripped, recovering;
   wire clear_thermal_and_retry;
   wire [7:0] panel_code, parameter_unit_code;
   int err_total, checks_done, i;
   // Short hold and recovery counts keep the run brief
   dft_trip_ctrl #(.RST_HOLD_CYC(24'h000005), .RECOVER_CYC(25'h0000014))
      dft_trip_ctrl_inst
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .control_power_ok(control_power_ok),
      .external_reset_terminal(external_reset_terminal),
      .stop_key(stop_key),
      .run_request(run_request),
      .motion_phase(motion_phase),
      .overcurrent_fault(overcurrent_fault),
      .overvoltage_fault(overvoltage_fault),
      .other_fault(other_fault),
      .other_fault_flagged(other_fault_flagged),
      .warning_flags(warning_flags),
      .fan_failure_alarm(fan_failure_alarm),
      .alarm_output_enable(alarm_output_enable),
      .parameter_write_error_messages(parameter_write_error_messages),
      .parameter_write_error(parameter_write_error),
      .legacy_parameter_unit(legacy_parameter_unit),
      .output_enable(output_enable),
      .fault_out(fault_out),
      .alarm_out(alarm_out),
      .tripped(tripped),
      .recovering(recovering),
      .panel_code(panel_code),
      .parameter_unit_code(parameter_unit_code),
      .clear_thermal_and_retry(clear_thermal_and_retry)
   );
   dft_panel_model dft_panel_model_inst
   (
      .clk(clk),
      .stop_key(stop_key),
      .external_reset_terminal(external_reset_terminal),
      .control_power_ok(control_power_ok)
   );
   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wait_ready();
      // Step off the edge so outputs are settled before looking
      #1;
      repeat (40)
         if (recovering !== 1'b0)
            step(1);
      chk("recovering", 8'h00, recovering);
      chk("output_enable", 8'h01, output_enable);
   endtask
   task report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Later faults must not overwrite the first code
   task trip_codes();
      for (i = 0; i < 6; i++)
      begin
         @(posedge clk);
         motion_phase <= 2'(i % 3);
         {overcurrent_fault, overvoltage_fault} <= (i < 3) ? 2'h2 : 2'h1;
         step(2);
         @(posedge clk);
         {overcurrent_fault, overvoltage_fault} <= 2'h3;
         step(2);
         chk("panel_code", 8'(8'h40 + i), panel_code);
         chk("fault_out", 8'h01, fault_out);
         chk("output_enable", 8'h00, output_enable);
         @(posedge clk);
         {overcurrent_fault, overvoltage_fault} <= 2'h0;
         dft_panel_model_inst.press();
         #1;
         chk("clear", 8'h01, clear_thermal_and_retry);
         wait_ready();
      end
      $display("trip codes done");
   endtask
   task classes();
      for (i = 0; i < 7; i++)
      begin
         @(posedge clk);
         warning_flags <= 7'(1 << i);
         step(2);
         chk("panel_code", 8'(8'h20 + i), panel_code);
         chk("tripped", 8'h00, tripped);
      end
      @(posedge clk);
      {warning_flags, fan_failure_alarm, alarm_output_enable} <= 9'h003;
      step(2);
      chk("alarm_out", 8'h01, alarm_out);
      chk("panel_code", 8'h30, panel_code);
      @(posedge clk);
      {fan_failure_alarm, parameter_write_error} <= 2'h1;
      step(2);
      chk("panel_code", 8'h13, panel_code);
      $display("classes done");
   endtask
   task reset_paths();
      @(posedge clk);
      {parameter_write_error, other_fault_flagged} <= 2'h1;
      {legacy_parameter_unit, other_fault} <= 7'h45;
      step(2);
      chk("panel_code", 8'h85, panel_code);
      chk("pu_code", 8'h0E, parameter_unit_code);
      @(posedge clk);
      other_fault <= 6'h00;
      dft_panel_model_inst.hold(4);
      step(2);
      chk("tripped", 8'h01, tripped);
      dft_panel_model_inst.hold(12);
      #1;
      chk("tripped", 8'h00, tripped);
      wait_ready();
      dft_panel_model_inst.hold(10);
      wait_ready();
      dft_panel_model_inst.press();
      #1;
      chk("recovering", 8'h00, recovering);
      @(posedge clk);
      overcurrent_fault <= 1'b1;
      step(2);
      @(posedge clk);
      overcurrent_fault <= 1'b0;
      dft_panel_model_inst.power_cycle();
      #1;
      chk("fault_out", 8'h00, fault_out);
      wait_ready();
      $display("reset paths done");
   endtask
   // Cut a hang short
   initial
   begin
      #(50 * 4000);
      err_total++;
      report_and_stop();
   end
   // Reset, then the scenarios in turn
   initial
   begin
      {err_total, checks_done} = '0;
      {sys_rst, run_request, motion_phase} = 4'hC;
      {overcurrent_fault, overvoltage_fault, other_fault} = 8'h00;
      {other_fault_flagged, fan_failure_alarm, alarm_output_enable} = 3'h0;
      {parameter_write_error, legacy_parameter_unit, warning_flags} = 9'h000;
      parameter_write_error_messages = 2'h3;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      step(1);
      wait_ready();
      trip_codes();
      classes();
      reset_paths();
      report_and_stop();
   end
endmodule
`default_nettype wire
